// ---- pkg/lin_resp_cfg.svh ----
`ifndef LIN_RESP_CFG_SVH
`define LIN_RESP_CFG_SVH

// ==========================================
// register byte offsets
`define OFS_CTRL 6'h00
`define OFS_CFG 6'h04
`define OFS_STATUS 6'h08
`define OFS_LEN 6'h0c
`define OFS_ID 6'h10
`define OFS_IRQ_ST 6'h14
`define OFS_IRQ_MASK 6'h18
`define OFS_BUF 6'h20

// ==========================================
// control register fields
`define CTRL_STOP 7
`define CTRL_DIR 5
`define CTRL_ACK 4
`define CTRL_RSTINT 3
`define CTRL_RSTERR 2

// ==========================================
// status register fields
`define ST_ACTIVE 7
`define ST_DREQ 4
`define ST_HALT 3
`define ST_BUSERR 2
`define ST_TMOERR 1
`define ST_DONE 0

// ==========================================
// interrupt fields
`define IRQ_ID 0
`define IRQ_ERR 1
`define IRQ_DONE 2
`define IRQ_W 3

// ==========================================
// sizes and reset values
`define BUF_DEPTH 8
`define IDX_W 3
`define LEN_W 4
`define ID_W 6
`define CTRL_RST 8'h00
`define CFG_RST 1'b0
`define MASK_RST 3'h0
`define UNMAPPED_DATA 32'h0000_0000

`endif

// ---- pkg/lin_resp_pkg.sv ----
package lin_resp_pkg;
    // ==========================================
    // frame tracker states, gray along idle-hdr-wack-data
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_HDR = 3'h1,
        ST_WACK = 3'h3,
        ST_DATA = 3'h2,
        ST_HALT = 3'h6
    } frame_state_t;
endpackage

// ---- pkg/frame_evt_if.sv ----
`include "lin_resp_cfg.svh"
interface frame_evt_if;
    // ==========================================
    // events into the tracker
    logic break_det;
    logic id_rx;
    logic byte_rx;
    logic byte_req;
    logic frame_done;
    logic bus_err;
    logic ack;
    logic stop;
    logic csum_change;
    // ==========================================
    // tracker state back to control
    logic dreq;
    logic halted;
    logic in_data;
    logic overrun;
    logic done;
    logic err;
    logic iface_reset;
    logic [`IDX_W-1:0] idx;

    modport tracker (
        input break_det, id_rx, byte_rx, byte_req, frame_done, bus_err, ack, stop,
        input csum_change,
        output dreq, halted, in_data, overrun, done, err, iface_reset, idx
    );
    modport ctrl (
        output break_det, id_rx, byte_rx, byte_req, frame_done, bus_err, ack, stop,
        output csum_change,
        input dreq, halted, in_data, overrun, done, err, iface_reset, idx
    );
endinterface

// ---- logic/frame_tracker.sv ----
`include "lin_resp_cfg.svh"
module frame_tracker (
    input wire logic clk_i,
    input wire logic rst_i,
    frame_evt_if.tracker ev
);
    lin_resp_pkg::frame_state_t state_q, state_d;
    logic dreq_q, dreq_d;
    logic [`IDX_W-1:0] idx_q, idx_d;
    logic overrun_d, done_d, err_d, rst_d;
    logic overrun_q, done_q, err_q, rstp_q;

    // ==========================================
    // next state of the frame sequence
    always_comb begin
        state_d = state_q;
        dreq_d = dreq_q;
        idx_d = idx_q;
        overrun_d = 1'b0;
        done_d = 1'b0;
        err_d = 1'b0;
        rst_d = 1'b0;
        case (state_q)
            lin_resp_pkg::ST_IDLE: begin
                if (ev.break_det) state_d = lin_resp_pkg::ST_HDR;
            end
            lin_resp_pkg::ST_HDR: begin
                if (ev.id_rx) begin
                    state_d = lin_resp_pkg::ST_WACK;
                    dreq_d = 1'b1;
                    idx_d = '0;
                end
            end
            lin_resp_pkg::ST_WACK: begin
                if (ev.stop) begin
                    state_d = lin_resp_pkg::ST_HALT;
                    dreq_d = 1'b0;
                end else if (ev.byte_rx) begin
                    // byte beat firmware setup: slot 0 overwritten, timeout
                    state_d = lin_resp_pkg::ST_IDLE;
                    dreq_d = 1'b0;
                    overrun_d = 1'b1;
                end else if (ev.ack) begin
                    state_d = lin_resp_pkg::ST_DATA;
                    dreq_d = 1'b0;
                end
            end
            lin_resp_pkg::ST_DATA: begin
                if (ev.frame_done) begin
                    state_d = lin_resp_pkg::ST_IDLE;
                    done_d = 1'b1;
                end else if (ev.byte_rx || ev.byte_req) begin
                    idx_d = idx_q + `IDX_W'(1);
                end
            end
            lin_resp_pkg::ST_HALT: begin
                // bus ignored until next sync break
                if (ev.break_det) state_d = lin_resp_pkg::ST_HDR;
            end
            default: begin
                state_d = lin_resp_pkg::ST_IDLE;
                dreq_d = 1'b0;
            end
        endcase
        // fresh break restarts header detection from any active state
        if (ev.break_det && state_q != lin_resp_pkg::ST_IDLE &&
            state_q != lin_resp_pkg::ST_HALT) begin
            state_d = lin_resp_pkg::ST_HDR;
            dreq_d = 1'b0;
        end
        if (ev.bus_err && state_q != lin_resp_pkg::ST_IDLE &&
            state_q != lin_resp_pkg::ST_HALT) begin
            state_d = lin_resp_pkg::ST_IDLE;
            dreq_d = 1'b0;
            err_d = 1'b1;
        end
        // checksum change mid-transaction discards the frame
        if (ev.csum_change && state_q != lin_resp_pkg::ST_IDLE &&
            state_q != lin_resp_pkg::ST_HALT) begin
            state_d = lin_resp_pkg::ST_IDLE;
            dreq_d = 1'b0;
            idx_d = '0;
            done_d = 1'b0;
            overrun_d = 1'b0;
            err_d = 1'b0;
            rst_d = 1'b1;
        end
    end

    // ==========================================
    // state registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= lin_resp_pkg::ST_IDLE;
            dreq_q <= 1'b0;
            idx_q <= '0;
            overrun_q <= 1'b0;
            done_q <= 1'b0;
            err_q <= 1'b0;
            rstp_q <= 1'b0;
        end else begin
            state_q <= state_d;
            dreq_q <= dreq_d;
            idx_q <= idx_d;
            overrun_q <= overrun_d;
            done_q <= done_d;
            err_q <= err_d;
            rstp_q <= rst_d;
        end
    end

    // ==========================================
    // outputs back to control
    assign ev.dreq = dreq_q;
    assign ev.halted = (state_q == lin_resp_pkg::ST_HALT);
    assign ev.in_data = (state_q == lin_resp_pkg::ST_DATA);
    assign ev.overrun = overrun_q;
    assign ev.done = done_q;
    assign ev.err = err_q;
    assign ev.iface_reset = rstp_q;
    assign ev.idx = idx_q;
endmodule

// ---- logic/lin_slave_response_control.sv ----
`include "lin_resp_cfg.svh"
module lin_slave_response_control (
    input wire logic clk_i,
    input wire logic rst_i,
    // wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // lin protocol engine events
    input wire logic break_det_i,
    input wire logic id_rx_i,
    input wire logic [`ID_W-1:0] id_i,
    input wire logic byte_rx_i,
    input wire logic [7:0] rx_byte_i,
    input wire logic byte_req_i,
    input wire logic frame_done_i,
    input wire logic bus_err_i,
    input wire logic bus_active_i,
    // toward the engine
    output logic hdr_enable_o,
    output logic iface_reset_o,
    output logic frame_direction_o,
    output logic csum_mode_o,
    output logic [`LEN_W-1:0] frame_len_o,
    output logic [7:0] tx_byte_o,
    output logic irq_o
);
    frame_evt_if ev ();

    logic ack_q, ack_d;
    logic [31:0] rdat_q, rdat_d;
    logic dir_q, dir_d;
    logic csum_q, csum_d;
    logic [`LEN_W-1:0] len_q, len_d;
    logic [`ID_W-1:0] id_q, id_d;
    logic [`IRQ_W-1:0] irq_st_q, irq_st_d, mask_q, mask_d;
    logic done_q, done_d, tmo_q, tmo_d, berr_q, berr_d;
    logic [7:0] tx_q, tx_d;
    logic [7:0] buf_q [`BUF_DEPTH];
    logic [7:0] buf_d [`BUF_DEPTH];
    logic wr_hit, rd_hit, buf_open, buf_sel, lane0;
    logic [`IDX_W-1:0] buf_idx;

    // ==========================================
    // bus decode; writes act on the edge that ends ack
    assign wr_hit = cyc_i && stb_i && we_i && ack_q;
    assign rd_hit = cyc_i && stb_i && !we_i && !ack_q;
    assign lane0 = sel_i[0];
    assign buf_sel = (adr_i[5] == 1'b1) && (adr_i[1:0] == 2'b00);
    assign buf_idx = adr_i[4:2];
    // firmware sees buffer and id only in a quiet, granted window
    assign buf_open = !bus_active_i && (ev.dreq || done_q);

    // ==========================================
    // events into the tracker
    assign ev.break_det = break_det_i;
    assign ev.id_rx = id_rx_i;
    assign ev.byte_rx = byte_rx_i;
    assign ev.byte_req = byte_req_i;
    assign ev.frame_done = frame_done_i;
    assign ev.bus_err = bus_err_i;
    // acknowledge and stop are write-one pulses in control
    assign ev.ack = wr_hit && lane0 && adr_i == `OFS_CTRL && dat_i[`CTRL_ACK];
    assign ev.stop = wr_hit && lane0 && adr_i == `OFS_CTRL && dat_i[`CTRL_STOP];
    assign ev.csum_change = wr_hit && lane0 && adr_i == `OFS_CFG && (dat_i[0] != csum_q);

    frame_tracker u_tracker (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .ev(ev.tracker)
    );

    // ==========================================
    // register next values
    always_comb begin
        dir_d = dir_q;
        csum_d = csum_q;
        len_d = len_q;
        mask_d = mask_q;
        id_d = id_q;
        done_d = done_q;
        tmo_d = tmo_q;
        berr_d = berr_q;
        irq_st_d = irq_st_q;
        if (wr_hit && lane0) begin
            case (adr_i)
                `OFS_CTRL: begin
                    dir_d = dat_i[`CTRL_DIR];
                    if (dat_i[`CTRL_RSTINT]) begin
                        irq_st_d = '0;
                        done_d = 1'b0;
                    end
                    if (dat_i[`CTRL_RSTERR]) begin
                        tmo_d = 1'b0;
                        berr_d = 1'b0;
                    end
                end
                `OFS_CFG: csum_d = dat_i[0];
                `OFS_LEN: len_d = dat_i[`LEN_W-1:0];
                `OFS_IRQ_ST: irq_st_d = irq_st_q & ~dat_i[`IRQ_W-1:0];
                `OFS_IRQ_MASK: mask_d = dat_i[`IRQ_W-1:0];
                default: ;
            endcase
        end
        // hardware sets after clears so a same-cycle event survives
        // identifier stored verbatim; no extended-frame decode here
        if (id_rx_i && !ev.halted) id_d = id_i;
        if (ev.id_rx && !ev.halted && ev.dreq == 1'b0) irq_st_d[`IRQ_ID] = 1'b1;
        if (ev.done) begin
            done_d = 1'b1;
            irq_st_d[`IRQ_DONE] = 1'b1;
        end
        if (ev.overrun) begin
            tmo_d = 1'b1;
            irq_st_d[`IRQ_ERR] = 1'b1;
        end
        if (ev.err) begin
            berr_d = 1'b1;
            irq_st_d[`IRQ_ERR] = 1'b1;
        end
        if (ev.iface_reset) done_d = 1'b0;
    end

    // ==========================================
    // data buffer, one entry per generate step
    for (genvar g = 0; g < `BUF_DEPTH; g++) begin : g_buf
        always_comb begin
            buf_d[g] = buf_q[g];
            if (wr_hit && lane0 && buf_sel && buf_open && buf_idx == `IDX_W'(g)) begin
                buf_d[g] = dat_i[7:0];
            end
            if (byte_rx_i && ev.in_data && ev.idx == `IDX_W'(g)) begin
                buf_d[g] = rx_byte_i;
            end
            if (g == 0 && byte_rx_i && ev.dreq && !ev.halted) begin
                buf_d[g] = rx_byte_i;
            end
        end
        always_ff @(posedge clk_i) begin
            if (rst_i) begin
                buf_q[g] <= 8'h00;
            end else begin
                buf_q[g] <= buf_d[g];
            end
        end
    end

    // ==========================================
    // read mux and bus answer
    always_comb begin
        ack_d = cyc_i && stb_i && !ack_q;
        rdat_d = rdat_q;
        tx_d = tx_q;
        if (byte_req_i && ev.in_data && dir_q) tx_d = buf_q[ev.idx];
        if (rd_hit) begin
            rdat_d = `UNMAPPED_DATA;
            if (buf_sel) begin
                if (buf_open) rdat_d = {24'h000000, buf_q[buf_idx]};
            end else begin
                case (adr_i)
                    `OFS_CTRL: rdat_d = {26'h0000000, dir_q, 5'h00};
                    `OFS_CFG: rdat_d = {31'h00000000, csum_q};
                    `OFS_STATUS: rdat_d = {24'h000000, bus_active_i, 2'b00, ev.dreq,
                        ev.halted, berr_q, tmo_q, done_q};
                    `OFS_LEN: rdat_d = {28'h0000000, len_q};
                    `OFS_ID: if (buf_open) rdat_d = {26'h0000000, id_q};
                    `OFS_IRQ_ST: rdat_d = {29'h00000000, irq_st_q};
                    `OFS_IRQ_MASK: rdat_d = {29'h00000000, mask_q};
                    default: rdat_d = `UNMAPPED_DATA;
                endcase
            end
        end
    end

    // ==========================================
    // register bank
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
            dir_q <= 1'b0;
            csum_q <= `CFG_RST;
            len_q <= '0;
            id_q <= '0;
            mask_q <= `MASK_RST;
            irq_st_q <= '0;
            done_q <= 1'b0;
            tmo_q <= 1'b0;
            berr_q <= 1'b0;
            tx_q <= 8'h00;
        end else begin
            ack_q <= ack_d;
            rdat_q <= rdat_d;
            dir_q <= dir_d;
            csum_q <= csum_d;
            len_q <= len_d;
            id_q <= id_d;
            mask_q <= mask_d;
            irq_st_q <= irq_st_d;
            done_q <= done_d;
            tmo_q <= tmo_d;
            berr_q <= berr_d;
            tx_q <= tx_d;
        end
    end

    // ==========================================
    // outputs
    assign ack_o = ack_q;
    assign dat_o = rdat_q;
    assign irq_o = |(irq_st_q & mask_q);
    assign hdr_enable_o = !ev.halted;
    assign iface_reset_o = ev.iface_reset;
    assign frame_direction_o = dir_q;
    assign csum_mode_o = csum_q;
    assign frame_len_o = len_q;
    assign tx_byte_o = tx_q;
endmodule

// ---- sim/lin_resp_checker.sv ----
`include "lin_resp_cfg.svh"
module lin_resp_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [5:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic break_det_i,
    input wire logic id_rx_i,
    input wire logic byte_rx_i,
    input wire logic byte_req_i,
    input wire logic frame_done_i,
    input wire logic bus_err_i,
    input wire logic bus_active_i,
    input wire logic hdr_enable_o,
    input wire logic iface_reset_o,
    input wire logic csum_mode_o,
    input wire logic [7:0] tx_byte_o,
    input wire logic irq_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic cfg_wr;
    // ==========================================
    // bus steps
    assign cfg_wr = ack_o && we_i && adr_i == `OFS_CFG;
    sequence req_taken;
        cyc_i && stb_i && !ack_o;
    endsequence
    sequence one_ack;
        ack_o ##1 !ack_o;
    endsequence
    // ==========================================
    // assertions
    bus_answer_a: assert property (req_taken |=> one_ack)
        else $error("bus request not answered in one cycle");
    refused_read_a: assert property (ack_o && !we_i && (adr_i == `OFS_ID || adr_i >= `OFS_BUF)
        && $past(bus_active_i) |-> dat_o == 32'h0)
        else $error("buffer or identifier readable while bus active");
    halt_hold_a: assert property (!hdr_enable_o && !break_det_i |=> !hdr_enable_o)
        else $error("halt left without sync break");
    halt_leave_a: assert property ($rose(hdr_enable_o) |-> $past(break_det_i))
        else $error("header detection resumed without break");
    iface_cause_a: assert property (iface_reset_o |-> $past(cfg_wr) || $past(cfg_wr, 2))
        else $error("interface reset without config write");
    iface_pulse_a: assert property (iface_reset_o |=> !iface_reset_o)
        else $error("interface reset longer than one cycle");
    csum_hold_a: assert property ($changed(csum_mode_o) |-> $past(cfg_wr))
        else $error("checksum mode changed without write");
    irq_cause_a: assert property ($rose(irq_o) |-> $past(ack_o) || $past(id_rx_i)
        || $past(bus_err_i, 2) || $past(frame_done_i, 2) || $past(byte_rx_i, 2)
        || $past(byte_rx_i, 3))
        else $error("interrupt rose without cause");
    tx_update_a: assert property ($changed(tx_byte_o) |-> $past(byte_req_i)
        || $past(byte_req_i, 2))
        else $error("transmit byte changed without request");
endmodule

bind lin_slave_response_control lin_resp_checker lin_resp_checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .break_det_i(break_det_i),
    .id_rx_i(id_rx_i), .byte_rx_i(byte_rx_i), .byte_req_i(byte_req_i),
    .frame_done_i(frame_done_i), .bus_err_i(bus_err_i), .bus_active_i(bus_active_i),
    .hdr_enable_o(hdr_enable_o), .iface_reset_o(iface_reset_o),
    .csum_mode_o(csum_mode_o), .tx_byte_o(tx_byte_o), .irq_o(irq_o));

// ---- sim/lin_master_model.sv ----
module lin_master_model (
    input wire logic clk_i,
    output logic break_det_o,
    output logic id_rx_o,
    output logic [5:0] id_o,
    output logic byte_rx_o,
    output logic [7:0] rx_byte_o,
    output logic byte_req_o,
    output logic frame_done_o,
    output logic bus_err_o,
    output logic bus_active_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // idle bus at time zero
    initial begin
        {break_det_o, id_rx_o, byte_rx_o, byte_req_o, frame_done_o, bus_err_o} = 6'h0;
        bus_active_o = 1'b0;
        id_o = 6'h15;
        rx_byte_o = 8'h96;
    end
    // ==========================================
    // header, break optional; bus quiet in response space
    task automatic header(input logic brk, input logic [5:0] id);
        bus_active_o <= 1'b1;
        if (brk) begin
            break_det_o <= 1'b1;
            @(posedge clk_i);
            break_det_o <= 1'b0;
        end
        id_rx_o <= 1'b1;
        id_o <= id;
        @(posedge clk_i);
        id_rx_o <= 1'b0;
        id_o <= ~id; // released line shows other value
        bus_active_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    // one received data byte
    task automatic rx(input logic [7:0] b);
        byte_rx_o <= 1'b1;
        rx_byte_o <= b;
        @(posedge clk_i);
        byte_rx_o <= 1'b0;
        rx_byte_o <= ~b;
        @(posedge clk_i);
    endtask
    // asks one byte with a single-cycle request, then waits two cycles
    task automatic req();
        byte_req_o <= 1'b1;
        @(posedge clk_i);
        byte_req_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    // end of message
    task automatic done();
        frame_done_o <= 1'b1;
        @(posedge clk_i);
        frame_done_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    // bus error seen by the engine
    task automatic err();
        bus_err_o <= 1'b1;
        @(posedge clk_i);
        bus_err_o <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    // bus busy level
    task automatic busy(input logic a);
        bus_active_o <= a;
        @(posedge clk_i);
    endtask
endmodule

// ---- sim/testbench.sv ----
`include "lin_resp_cfg.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic [5:0] adr_i = 6'h00;
    logic [3:0] sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0, dat_o;
    logic ack_o, break_det_i, id_rx_i, byte_rx_i, byte_req_i, frame_done_i, bus_err_i;
    logic bus_active_i, hdr_enable_o, iface_reset_o, frame_direction_o, csum_mode_o, irq_o;
    logic [`ID_W-1:0] id_i, id;
    logic [7:0] rx_byte_i, tx_byte_o, resets = 8'h0;
    logic [`LEN_W-1:0] frame_len_o;
    logic [63:0] notes[$], n;
    logic [7:0] b[8];
    int fails = 0, comparisons = 0;
    lin_slave_response_control lin_slave_response_control_inst (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .break_det_i(break_det_i), .id_rx_i(id_rx_i), .id_i(id_i), .byte_rx_i(byte_rx_i),
        .rx_byte_i(rx_byte_i), .byte_req_i(byte_req_i), .frame_done_i(frame_done_i),
        .bus_err_i(bus_err_i), .bus_active_i(bus_active_i), .hdr_enable_o(hdr_enable_o),
        .iface_reset_o(iface_reset_o), .frame_direction_o(frame_direction_o),
        .csum_mode_o(csum_mode_o), .frame_len_o(frame_len_o), .tx_byte_o(tx_byte_o),
        .irq_o(irq_o));
    lin_master_model m (.clk_i(clk_i), .break_det_o(break_det_i), .id_rx_o(id_rx_i),
        .id_o(id_i), .byte_rx_o(byte_rx_i), .rx_byte_o(rx_byte_i), .byte_req_o(byte_req_i),
        .frame_done_o(frame_done_i), .bus_err_o(bus_err_i), .bus_active_o(bus_active_i));
    // clock
    initial begin
        forever #2 clk_i = ~clk_i;
    end
    // read monitor takes oldest note
    always @(posedge clk_i) begin
        if (ack_o === 1'b1 && we_i === 1'b0 && notes.size() > 0) begin
            n = notes.pop_front();
            comparisons++;
            if ((dat_o & n[31:0]) !== n[63:32]) begin
                fails++;
                $display("CHECK FAILED %0t read %h got %h", $time, adr_i, dat_o);
            end
        end
        if (iface_reset_o === 1'b1) resets <= resets + 8'h1;
    end
    // ==========================================
    // tasks
    task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d);
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hf};
        // waits for the answer; only the watchdog ends a hang
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e, input logic [31:0] mk);
        notes.push_back({e, mk});
        wb(1'b0, a, 32'h0);
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %0t level got %h want %h", $time, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // watchdog
    initial begin
        repeat (20000) @(posedge clk_i);
        fails++;
        stop_test();
    end
    // ==========================================
    // main sequence
    initial begin
        void'($urandom(32'h768234dd));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk(hdr_enable_o, 1);
        rd(`OFS_STATUS, 0, 32'hff);
        rd(`OFS_IRQ_MASK, 0, 32'h7);
        rd(6'h1c, 0, 32'hffffffff);
        $display("reset values done");
        wr_frame: begin
            wb(1, `OFS_IRQ_MASK, 7);
            id = 6'($urandom);
            m.header(1, id);
            chk(irq_o, 1);
            rd(`OFS_STATUS, 32'h10, 32'h9f);
            m.busy(1);
            rd(`OFS_ID, 0, 32'hff);
            m.busy(0);
            rd(`OFS_ID, id, 32'h3f);
            wb(1, `OFS_LEN, 3);
            wb(1, `OFS_CTRL, 32'h10);
            for (int i = 0; i < 3; i++) begin
                b[i] = 8'($urandom);
                m.rx(b[i]);
            end
            m.done();
            rd(`OFS_STATUS, 1, 32'h1f);
            for (int i = 0; i < 3; i++) rd(`OFS_BUF + 6'(i * 4), b[i], 32'hff);
            wb(1, `OFS_IRQ_ST, 7);
            chk(irq_o, 0);
            $display("receive frame done");
        end
        wb(1, `OFS_CTRL, 32'h0c);
        m.header(1, id);
        m.rx(8'h5a);
        repeat (3) @(posedge clk_i);
        rd(`OFS_IRQ_ST, 3, 7);
        rd(`OFS_STATUS, 2, 32'h02);
        $display("early byte done");
        wb(1, `OFS_CTRL, 32'h0c);
        wb(1, `OFS_IRQ_MASK, 0);
        m.header(1, 6'h3e);
        chk(irq_o, 0);
        wb(1, `OFS_IRQ_MASK, 7);
        chk(irq_o, 1);
        rd(`OFS_ID, 6'h3e, 32'h3f);
        wb(1, `OFS_CTRL, 32'h80);
        chk(hdr_enable_o, 0);
        rd(`OFS_STATUS, 8, 8);
        wb(1, `OFS_CTRL, 32'h0c);
        m.header(0, id);
        chk(irq_o, 0);
        m.header(1, id);
        chk(hdr_enable_o, 1);
        chk(irq_o, 1);
        $display("stop done");
        wb(1, `OFS_CTRL, 32'h0c);
        wb(1, `OFS_CTRL, 32'h10);
        m.rx(8'h33);
        chk(resets, 0);
        wb(1, `OFS_CFG, 1);
        chk(csum_mode_o, 1);
        repeat (3) @(posedge clk_i);
        chk(resets, 1);
        m.done();
        rd(`OFS_STATUS, 0, 32'h11);
        wb(1, `OFS_CFG, 0);
        repeat (3) @(posedge clk_i);
        chk(resets, 1);
        chk(csum_mode_o, 0);
        $display("checksum change done");
        wb(1, `OFS_CTRL, 32'h0c);
        m.header(1, id);
        wb(1, `OFS_CTRL, 32'h20);
        wb(1, `OFS_LEN, 2);
        for (int i = 0; i < 2; i++) begin
            b[i] = 8'($urandom);
            wb(1, `OFS_BUF + 6'(i * 4), {24'h0, b[i]});
        end
        wb(1, `OFS_CTRL, 32'h30);
        chk(frame_direction_o, 1);
        chk(frame_len_o, 2);
        for (int i = 0; i < 2; i++) begin
            m.req();
            chk(tx_byte_o, b[i]);
        end
        m.done();
        rd(`OFS_STATUS, 1, 1);
        $display("transmit frame done");
        wb(1, `OFS_CTRL, 32'h0c);
        m.header(1, id);
        wb(1, `OFS_CTRL, 32'h10);
        wb(1, `OFS_IRQ_MASK, 2);
        chk(irq_o, 0);
        m.err();
        chk(irq_o, 1);
        rd(`OFS_STATUS, 4, 32'h1f);
        $display("bus error done");
        stop_test();
    end
endmodule
